// *** link_host_model.sv ***
// host cpu model on the three-wire register link
`timescale 1ns/10ps
module link_host_model (
    output logic sclk_o,
    output logic ce_o,
    output logic sio_line_o,
    input wire logic sio_dev_i,
    input wire logic sio_oe_n_i
);
    import rtc_pkg::*;
    logic drive = 1'b0, bit_r = 1'b0;
    initial {sclk_o, ce_o} = 2'b00;
    // released line shows the inverse of the last driven bit
    assign sio_line_o = !sio_oe_n_i ? sio_dev_i : (drive ? bit_r : ~bit_r);

    ////////////////////////////////////////////////////////////////////////////
    task automatic send_byte(input logic [7:0] b);
        drive = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            bit_r = b[i];
            #40 sclk_o = 1'b1;
            #40 sclk_o = 1'b0;
        end
    endtask : send_byte

    task automatic recv_byte(output logic [7:0] b);
        drive = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #40 sclk_o = 1'b1;
            b[i] = sio_line_o;
            #40 sclk_o = 1'b0;
        end
    endtask : recv_byte

    task automatic end_frame();
        #80 ce_o = 1'b0;
        drive = 1'b0;
        #100;
    endtask : end_frame

    task automatic write_reg(input logic [3:0] addr, input logic [7:0] d);
        #13 ce_o = 1'b1;
        send_byte({addr, 4'h0});
        send_byte(d);
        end_frame();
    endtask : write_reg

    task automatic write_time(input time_t t);
        #13 ce_o = 1'b1;
        send_byte(8'h00);
        send_byte(t.sec);
        send_byte(t.min);
        send_byte(t.hour);
        send_byte(t.wday);
        end_frame();
    endtask : write_time

    task automatic read_reg(input logic [3:0] addr, output logic [7:0] d);
        #13 ce_o = 1'b1;
        send_byte({addr, 4'h8});
        recv_byte(d);
        end_frame();
    endtask : read_reg
endmodule : link_host_model

// *** rtc_core.sv ***
// status flags, time counters and serial register link of the clock
`timescale 1ns/10ps
`include "rtc_defs.svh"

// Summary of operation
// (R1) supply-low set stops monitoring, stays set
// (R2) write 0 clears supply-low, restarts monitor
// (R3) oscillator halt sets halt flag
// (R4) halt flag clears only by writing 0
// (R5) power-on sets power-on flag, held
// (R6) power-on flag zeroes control, releases interrupt
// (R7) power-on flag clears only by 0
// (R8) scratch bit two read/write, zeroed by power-on
// (R9) periodic interrupt low sets periodic flag
// (R10) level mode: writing 0 releases interrupt
// (R11) enabled alarm flag set 15us after match
// (R12) alarm flag cleared by 0, releases interrupt
// (R13) alarm flag reads 0 when disabled
// (R14) seconds, minutes count BCD 00-59 with carry
// (R15) hour wrap gives day carry, both modes
// (R16) seconds write resets sub-second divider
// (R17) weekday counts 0 to 6 then wraps
// (R18) software never writes weekday value 7
// (R19) software writes only valid time values
// (R20) BCD fields, hour bit 5, unused bits zero
// (R21) interrupt active low from enabled flags
// (R22) one-second tick divided from oscillator
module rtc_core #(
    parameter int DIV_COUNT = `OSC_DIV_COUNT
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic ce_i,
    input wire logic sio_i,
    output logic sio_o,
    output logic sio_oe_n_o,
    input wire logic osc_32k_i,
    input wire logic osc_stopped_i,
    input wire logic supply_below_i,
    input wire logic [1:0] alarm_match_i,
    input wire logic month_carry_i,
    output logic monitor_enable_o,
    output logic irq_out_n_o,
    output logic day_carry_o,
    output rtc_pkg::time_t time_o
);
    import rtc_pkg::*;

    localparam int DW = $clog2(DIV_COUNT);
    localparam logic [DW-1:0] DIV_LAST = DW'(DIV_COUNT - 1);
    localparam logic [DW-1:0] DIV_HALF = DW'(DIV_COUNT / 2);
    localparam logic [DW-1:0] DIV_QTR = DW'(DIV_COUNT / 4);
    localparam logic [10:0] ALARM_LAST = 11'(`ALARM_DELAY_CYC - 1);

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction : bcd_inc

    ////////////////////////////////////////////////////////////////////////
    // link side, clocked by the serial clock
    logic link_rst_n;
    link_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [3:0] addr_reg;
    logic [7:0] byte_next;
    logic [7:0] out_sh_reg;
    link_write_t wr_hold_reg;
    logic wr_tog_reg;
    logic [7:0] snap [16];

    assign link_rst_n = rst_n_i & ce_i;
    assign byte_next = {shift_reg, sio_i};

    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_reg <= ST_CMD;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            addr_reg <= 4'h0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= byte_next[6:0];
            if (bit_cnt_reg == 3'h7) begin
                if (state_reg == ST_CMD) begin
                    addr_reg <= byte_next[7:4];
                    state_reg <= byte_next[`CMD_READ_BIT] ? ST_READ : ST_WRITE;
                end else begin
                    addr_reg <= addr_reg + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_hold_reg <= '0;
            wr_tog_reg <= 1'b0;
        end else if (ce_i && state_reg == ST_WRITE && bit_cnt_reg == 3'h7) begin
            wr_hold_reg <= '{addr: addr_reg, data: byte_next};
            wr_tog_reg <= ~wr_tog_reg;
        end
    end

    // read data leaves on the falling edge
    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            out_sh_reg <= 8'h00;
        end else if (state_reg == ST_READ) begin
            out_sh_reg <= (bit_cnt_reg == 3'h0) ? snap[addr_reg] : {out_sh_reg[6:0], 1'b0};
        end
    end

    assign sio_o = out_sh_reg[7];
    assign sio_oe_n_o = (state_reg != ST_READ);

    ////////////////////////////////////////////////////////////////////////
    // crossings and pin synchronisers
    logic [2:0] wr_sync_reg;
    logic [1:0] ce_sync_reg;
    logic [2:0] osc_sync_reg;
    logic [1:0] halt_sync_reg;
    logic [1:0] low_sync_reg;
    logic wr_stb;
    link_write_t wr;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_sync_reg <= 3'h0;
            ce_sync_reg <= 2'h0;
            osc_sync_reg <= 3'h0;
            halt_sync_reg <= 2'h0;
            low_sync_reg <= 2'h0;
        end else begin
            wr_sync_reg <= {wr_sync_reg[1:0], wr_tog_reg};
            ce_sync_reg <= {ce_sync_reg[0], ce_i};
            osc_sync_reg <= {osc_sync_reg[1:0], osc_32k_i};
            halt_sync_reg <= {halt_sync_reg[0], osc_stopped_i};
            low_sync_reg <= {low_sync_reg[0], supply_below_i};
        end
    end

    assign wr_stb = wr_sync_reg[2] ^ wr_sync_reg[1];
    assign wr = wr_hold_reg;

    ////////////////////////////////////////////////////////////////////////
    // status flags and control registers
    logic power_on_flag_reg;
    logic supply_low_flag_reg;
    logic osc_halt_flag_reg;
    logic scratch_bit_one_reg;
    logic scratch_bit_two_reg;
    logic periodic_irq_flag_reg;
    logic [1:0] alarm_flag_reg;
    logic [7:0] ctrl1_reg;
    logic [7:0] osc_adjust_reg;
    logic wr_ctrl2;
    logic [1:0] alarm_enable;
    logic [1:0] alarm_hit;
    logic periodic_event;
    logic phase_low;
    ct_mode_t ct_mode;

    assign wr_ctrl2 = wr_stb && wr.addr == `CTRL2_OFS;
    assign ct_mode = ct_mode_t'(ctrl1_reg[2:0]);
    assign alarm_enable = {ctrl1_reg[`CTRL1_WEEKDAY_ALARM_ENABLE_BIT], ctrl1_reg[`CTRL1_DAILY_ALARM_ENABLE_BIT]};

    // (R5) flag set at power-up
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_on_flag_reg <= 1'b1;
        // (R7) zero write clears
        end else if (wr_ctrl2 && !wr.data[`CTRL2_PON_BIT]) begin
            power_on_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            supply_low_flag_reg <= 1'b1;
        // (R1) set and hold
        end else if (low_sync_reg[1] && !supply_low_flag_reg) begin
            supply_low_flag_reg <= 1'b1;
        // (R2) zero write clears
        end else if (wr_ctrl2 && !wr.data[`CTRL2_VLOW_BIT]) begin
            supply_low_flag_reg <= 1'b0;
        end
    end

    // (R1) monitor stops while set
    assign monitor_enable_o = ~supply_low_flag_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_halt_flag_reg <= 1'b1;
        // (R3) halt sets flag
        end else if (halt_sync_reg[1]) begin
            osc_halt_flag_reg <= 1'b1;
        // (R4) only zero clears
        end else if (wr_ctrl2 && !wr.data[`CTRL2_XHALT_BIT]) begin
            osc_halt_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scratch_bit_one_reg <= 1'b0;
            scratch_bit_two_reg <= 1'b0;
        // (R8) power-on zeroes scratch
        end else if (power_on_flag_reg) begin
            scratch_bit_one_reg <= 1'b0;
            scratch_bit_two_reg <= 1'b0;
        // (R8) scratch read/write
        end else if (wr_ctrl2) begin
            scratch_bit_one_reg <= wr.data[`CTRL2_SCR1_BIT];
            scratch_bit_two_reg <= wr.data[`CTRL2_SCR2_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl1_reg <= `CTRL1_RESET;
            osc_adjust_reg <= `OSC_ADJUST_RESET;
        // (R6) power-on zeroes control
        end else if (power_on_flag_reg) begin
            ctrl1_reg <= `CTRL1_RESET;
            osc_adjust_reg <= `OSC_ADJUST_RESET;
        end else if (wr_stb && wr.addr == `CTRL1_OFS) begin
            ctrl1_reg <= wr.data;
        end else if (wr_stb && wr.addr == `OSC_ADJUST_OFS) begin
            osc_adjust_reg <= wr.data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            periodic_irq_flag_reg <= 1'b0;
        // (R6) cleared under power-on
        end else if (power_on_flag_reg || ct_mode == CT_OFF) begin
            periodic_irq_flag_reg <= 1'b0;
        // (R9) flag tracks low output
        end else if (ct_mode == CT_LOW) begin
            periodic_irq_flag_reg <= 1'b1;
        end else if (ct_mode == CT_2HZ || ct_mode == CT_1HZ) begin
            periodic_irq_flag_reg <= phase_low;
        // (R9) level event sets
        end else if (periodic_event) begin
            periodic_irq_flag_reg <= 1'b1;
        // (R10) level-mode zero write clears
        end else if (wr_ctrl2 && !wr.data[`CTRL2_PERIODIC_IRQ_FLAG_BIT]) begin
            periodic_irq_flag_reg <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_alarm
            logic [10:0] wait_reg;
            logic busy_reg;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    wait_reg <= 11'h000;
                    busy_reg <= 1'b0;
                end else if (!alarm_enable[g]) begin
                    busy_reg <= 1'b0;
                end else if (alarm_match_i[g] && !busy_reg) begin
                    busy_reg <= 1'b1;
                    wait_reg <= 11'h000;
                end else if (busy_reg) begin
                    wait_reg <= wait_reg + 11'h001;
                    busy_reg <= wait_reg != ALARM_LAST;
                end
            end
            // (R11) set after delay
            assign alarm_hit[g] = busy_reg && wait_reg == ALARM_LAST;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    alarm_flag_reg[g] <= 1'b0;
                // (R13) disabled alarm holds zero
                end else if (power_on_flag_reg || !alarm_enable[g]) begin
                    alarm_flag_reg[g] <= 1'b0;
                end else if (alarm_hit[g]) begin
                    alarm_flag_reg[g] <= 1'b1;
                // (R12) zero write clears
                end else if (wr_ctrl2 && !wr.data[g]) begin
                    alarm_flag_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // (R21) active-low interrupt
    assign irq_out_n_o = ~(periodic_irq_flag_reg | |(alarm_flag_reg & alarm_enable));

    ////////////////////////////////////////////////////////////////////////
    // divider and time counters
    logic [DW-1:0] div_reg;
    logic tick;
    logic wr_sec;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic [7:0] sec_reg;
    logic [7:0] min_reg;
    logic [7:0] hour_reg;
    logic [2:0] wday_reg;
    logic [7:0] hour_next;
    logic h24;

    assign wr_sec = wr_stb && wr.addr == `SECONDS_COUNT_OFS;
    assign h24 = ctrl1_reg[`CTRL1_H24_BIT];

    // (R22) one-second divider
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= '0;
        // (R16) seconds write restarts
        end else if (wr_sec) begin
            div_reg <= '0;
        end else if (osc_sync_reg[1] && !osc_sync_reg[2]) begin
            div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + DW'(1);
        end
    end

    assign tick = osc_sync_reg[1] && !osc_sync_reg[2] && div_reg == DIV_LAST;
    assign phase_low = (ct_mode == CT_1HZ) ? (div_reg < DIV_HALF) :
                       (div_reg < DIV_QTR) || (div_reg >= DIV_HALF && div_reg < DIV_HALF + DIV_QTR);

    // (R14) BCD wrap at 59
    assign sec_wrap = sec_reg == 8'h59;
    assign min_wrap = min_reg == 8'h59;
    // (R15) day carry points
    assign hour_wrap = h24 ? hour_reg == 8'h23 : hour_reg == 8'h31;

    // (R20) hour bit 5 is PM or twenty
    always_comb begin
        hour_next = bcd_inc(hour_reg);
        if (h24) begin
            hour_next = hour_wrap ? 8'h00 : bcd_inc(hour_reg);
        end else if (hour_reg[4:0] == 5'h11) begin
            hour_next = {2'b00, ~hour_reg[5], 5'h12};
        end else if (hour_reg[4:0] == 5'h12) begin
            hour_next = {2'b00, hour_reg[5], 5'h01};
        end else begin
            hour_next = {2'b00, hour_reg[5], 5'(bcd_inc({3'h0, hour_reg[4:0]}))};
        end
    end

    always_comb begin
        periodic_event = 1'b0;
        unique case (ct_mode)
            CT_SEC: periodic_event = tick;
            CT_MIN: periodic_event = tick && sec_wrap;
            CT_HOUR: periodic_event = tick && sec_wrap && min_wrap;
            CT_MONTH: periodic_event = month_carry_i;
            CT_OFF, CT_LOW, CT_2HZ, CT_1HZ: periodic_event = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_reg <= 8'h00;
        // (R20) unused bits read zero
        end else if (wr_sec) begin
            sec_reg <= {1'b0, wr.data[6:0]};
        // (R14) seconds count
        end else if (tick) begin
            sec_reg <= sec_wrap ? 8'h00 : bcd_inc(sec_reg);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            min_reg <= 8'h00;
        end else if (wr_stb && wr.addr == `MINUTES_COUNT_OFS) begin
            min_reg <= {1'b0, wr.data[6:0]};
        // (R14) minute carry in
        end else if (tick && sec_wrap) begin
            min_reg <= min_wrap ? 8'h00 : bcd_inc(min_reg);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hour_reg <= 8'h00;
            day_carry_o <= 1'b0;
        end else begin
            day_carry_o <= 1'b0;
            if (wr_stb && wr.addr == `HOURS_COUNT_OFS) begin
                hour_reg <= {2'b00, wr.data[5:0]};
            end else if (tick && sec_wrap && min_wrap) begin
                hour_reg <= hour_next;
                // (R15) day carry pulse
                day_carry_o <= hour_wrap;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wday_reg <= 3'h0;
        end else if (wr_stb && wr.addr == `WEEKDAY_COUNT_OFS) begin
            wday_reg <= wr.data[2:0];
        // (R17) weekday steps, wraps after 6
        end else if (tick && sec_wrap && min_wrap && hour_wrap) begin
            wday_reg <= (wday_reg >= 3'h6) ? 3'h0 : wday_reg + 3'h1;
        end
    end

    assign time_o = '{sec: sec_reg, min: min_reg, hour: hour_reg, wday: {5'h00, wday_reg}};

    ////////////////////////////////////////////////////////////////////////
    // read snapshot, frozen while a frame is open
    function automatic logic [7:0] read_byte(input logic [3:0] a);
        unique case (a)
            `SECONDS_COUNT_OFS: read_byte = sec_reg;
            `MINUTES_COUNT_OFS: read_byte = min_reg;
            `HOURS_COUNT_OFS: read_byte = hour_reg;
            `WEEKDAY_COUNT_OFS: read_byte = {5'h00, wday_reg};
            `OSC_ADJUST_OFS: read_byte = osc_adjust_reg;
            `CTRL1_OFS: read_byte = ctrl1_reg;
            // (R13) flags gated by enables
            `CTRL2_OFS: read_byte = {scratch_bit_one_reg, supply_low_flag_reg, osc_halt_flag_reg,
                power_on_flag_reg, scratch_bit_two_reg, periodic_irq_flag_reg,
                alarm_flag_reg & alarm_enable};
            default: read_byte = 8'h00;
        endcase
    endfunction : read_byte

    generate
        for (g = 0; g < 16; g++) begin : gen_snap
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    snap[g] <= 8'h00;
                end else if (!ce_sync_reg[1]) begin
                    snap[g] <= read_byte(4'(g));
                end
            end
        end
    endgenerate
endmodule : rtc_core

// *** rtc_core_assertions.sv ***
// concurrent checks on the ports of the clock core
`timescale 1ns/10ps
module rtc_core_checker #(
    parameter int DIV_COUNT = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic supply_below_i,
    input wire logic monitor_enable_o,
    input wire logic irq_out_n_o,
    input wire logic day_carry_o,
    input wire rtc_pkg::time_t time_o
);
    import rtc_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    function automatic logic [7:0] next60(input logic [7:0] v);
        if (v == 8'h59) begin
            return 8'h00;
        end
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return v + 8'h01;
    endfunction : next60

    ////////////////////////////////////////////////////////////////////////////
    sec_step_a: assert property (!ce_i && $changed(time_o.sec) |-> time_o.sec == next60($past(time_o.sec)))
        else $error("seconds stepped wrongly");
    min_carry_a: assert property (!ce_i && $changed(time_o.min) |->
        time_o.sec == 8'h00 && time_o.min == next60($past(time_o.min)))
        else $error("minutes stepped wrongly");
    wday_step_a: assert property (!ce_i && $changed(time_o.wday) |->
        time_o.wday == (($past(time_o.wday) == 8'h06) ? 8'h00 : $past(time_o.wday) + 8'h01))
        else $error("weekday stepped wrongly");
    carry_pulse_a: assert property (day_carry_o |=> !day_carry_o)
        else $error("day carry longer than one cycle");
    carry_hour_a: assert property (day_carry_o |-> time_o.hour inside {8'h00, 8'h12})
        else $error("day carry without hour wrap");
    unused_zero_a: assert property ({time_o.sec[7], time_o.min[7], time_o.hour[7:6], time_o.wday[7:3]} == 9'h000)
        else $error("unused time bits set");
    monitor_stop_a: assert property (supply_below_i |-> ##[0:4] !monitor_enable_o)
        else $error("monitor not stopped on low supply");
    monitor_hold_a: assert property (!monitor_enable_o && !ce_i |=> !monitor_enable_o)
        else $error("monitor restarted without a write");
    por_release_a: assert property ($rose(rst_n_i) |-> irq_out_n_o && !monitor_enable_o)
        else $error("power-on state wrong");
endmodule : rtc_core_checker

bind rtc_core rtc_core_checker #(.DIV_COUNT(DIV_COUNT)) u_checker (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .supply_below_i(supply_below_i),
    .monitor_enable_o(monitor_enable_o),
    .irq_out_n_o(irq_out_n_o),
    .day_carry_o(day_carry_o),
    .time_o(time_o)
);

// *** rtc_defs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define SECONDS_COUNT_OFS 4'h0
`define MINUTES_COUNT_OFS 4'h1
`define HOURS_COUNT_OFS 4'h2
`define WEEKDAY_COUNT_OFS 4'h3
`define OSC_ADJUST_OFS 4'h7
`define CTRL1_OFS 4'he
`define CTRL2_OFS 4'hf
`define CTRL1_WEEKDAY_ALARM_ENABLE_BIT 7
`define CTRL1_DAILY_ALARM_ENABLE_BIT 6
`define CTRL1_H24_BIT 5
`define CTRL2_SCR1_BIT 7
`define CTRL2_VLOW_BIT 6
`define CTRL2_XHALT_BIT 5
`define CTRL2_PON_BIT 4
`define CTRL2_SCR2_BIT 3
`define CTRL2_PERIODIC_IRQ_FLAG_BIT 2
`define CTRL2_WEEKDAY_ALARM_FLAG_BIT 1
`define CTRL2_DAILY_ALARM_FLAG_BIT 0
`define CMD_READ_BIT 3
`define CTRL1_RESET 8'h00
`define OSC_ADJUST_RESET 8'h00
`define OSC_DIV_COUNT 32768
`define CLK_PERIOD_NS 10
`define ALARM_DELAY_NS 15000
`define ALARM_DELAY_CYC (`ALARM_DELAY_NS / `CLK_PERIOD_NS)
`endif

// *** rtc_pkg.sv ***
// types shared by the real-time clock design
package rtc_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } link_write_t;
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wday;
    } time_t;
    typedef enum logic [1:0] {ST_CMD, ST_WRITE, ST_READ} link_state_t;
    typedef enum logic [2:0] {
        CT_OFF, CT_LOW, CT_2HZ, CT_1HZ, CT_SEC, CT_MIN, CT_HOUR, CT_MONTH
    } ct_mode_t;
endpackage : rtc_pkg

// *** rtc_status_flags_time_counters_test.sv ***
// self-checking bench for the clock core
`timescale 1ns/10ps
`include "rtc_defs.svh"
module rtc_status_flags_time_counters_test;
    import rtc_pkg::*;
    localparam int DIV = 8;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic osc_32k_i = 1'b0;
    logic osc_stopped_i = 1'b0, month_carry_i = 1'b0;
    logic supply_below_i = 1'b0;
    logic [1:0] alarm_match_i = 2'h0;
    logic sclk, ce, sio_line, sio_o, sio_oe_n_o, monitor_enable_o, irq_out_n_o, day_carry_o;
    time_t time_o;
    logic [7:0] rd;
    int n_fail = 0;
    int samples_checked = 0;

    always #5 clk_i = ~clk_i;
    always #400 osc_32k_i = ~osc_32k_i;

    rtc_core #(.DIV_COUNT(DIV)) u_dut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sclk_i(sclk),
        .ce_i(ce),
        .sio_i(sio_line),
        .sio_o(sio_o),
        .sio_oe_n_o(sio_oe_n_o),
        .osc_32k_i(osc_32k_i),
        .osc_stopped_i(osc_stopped_i),
        .supply_below_i(supply_below_i),
        .alarm_match_i(alarm_match_i),
        .month_carry_i(month_carry_i),
        .monitor_enable_o(monitor_enable_o),
        .irq_out_n_o(irq_out_n_o),
        .day_carry_o(day_carry_o),
        .time_o(time_o)
    );

    link_host_model u_host (
        .sclk_o(sclk),
        .ce_o(ce),
        .sio_line_o(sio_line),
        .sio_dev_i(sio_o),
        .sio_oe_n_i(sio_oe_n_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic final_report();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_clk

    task automatic wait_irq_low(input int lim);
        for (int k = 0; k < lim && irq_out_n_o !== 1'b0; k++) begin
            wait_clk(1);
        end
    endtask : wait_irq_low

    task automatic pulse_match(input int idx);
        wait_clk(1);
        alarm_match_i[idx] = 1'b1;
        wait_clk(1);
        alarm_match_i[idx] = 1'b0;
    endtask : pulse_match

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_power_on();
        wait_clk(3);
        check(irq_out_n_o, 1'b1, "irq after power-on");
        check(monitor_enable_o, 1'b0, "monitor after power-on");
        u_host.read_reg(`CTRL2_OFS, rd);
        check(rd, 8'h70, "power-on status");
        u_host.read_reg(`CTRL1_OFS, rd);
        check(rd, 8'h00, "control cleared");
    endtask : t_power_on

    task automatic t_flags();
        u_host.write_reg(`CTRL2_OFS, 8'hff);
        u_host.read_reg(`CTRL2_OFS, rd);
        check(rd, 8'h70, "ones ignored");
        u_host.write_reg(`CTRL2_OFS, 8'h00);
        u_host.read_reg(`CTRL2_OFS, rd);
        check(rd, 8'h00, "flags cleared");
        check(monitor_enable_o, 1'b1, "monitor restart");
        u_host.write_reg(`CTRL2_OFS, 8'h08);
        u_host.read_reg(`CTRL2_OFS, rd);
        check(rd, 8'h08, "scratch kept");
    endtask : t_flags

    task automatic t_detect();
        wait_clk(1);
        supply_below_i = 1'b1;
        osc_stopped_i = 1'b1;
        wait_clk(5);
        supply_below_i = 1'b0;
        osc_stopped_i = 1'b0;
        wait_clk(10);
        check(monitor_enable_o, 1'b0, "monitor stopped");
        u_host.write_reg(`CTRL2_OFS, 8'h68);
        u_host.read_reg(`CTRL2_OFS, rd);
        check(rd, 8'h68, "detect flags held");
        u_host.write_reg(`CTRL2_OFS, 8'h08);
        u_host.read_reg(`CTRL2_OFS, rd);
        check(rd, 8'h08, "detect flags cleared");
        check(monitor_enable_o, 1'b1, "monitor running");
    endtask : t_detect

    task automatic t_alarm(input int idx);
        logic [7:0] fl;
        fl = 8'h01 << idx;
        u_host.write_reg(`CTRL1_OFS, 8'h20 | (fl << 6));
        pulse_match(idx);
        wait_clk(1400);
        check(irq_out_n_o, 1'b1, "alarm too early");
        wait_irq_low(200);
        check(irq_out_n_o, 1'b0, "alarm irq");
        u_host.write_reg(`CTRL2_OFS, 8'h08 | fl);
        u_host.read_reg(`CTRL2_OFS, rd);
        check(rd, 8'h08 | fl, "alarm flag");
        u_host.write_reg(`CTRL2_OFS, 8'h08);
        check(irq_out_n_o, 1'b1, "alarm release");
        u_host.write_reg(`CTRL1_OFS, 8'h20);
        pulse_match(idx);
        wait_clk(1600);
        u_host.read_reg(`CTRL2_OFS, rd);
        check(rd, 8'h08, "disabled alarm flag");
        check(irq_out_n_o, 1'b1, "disabled alarm irq");
    endtask : t_alarm

    task automatic t_periodic();
        u_host.write_reg(`CTRL1_OFS, 8'h24);
        wait_irq_low(1400);
        check(irq_out_n_o, 1'b0, "periodic irq");
        u_host.read_reg(`CTRL2_OFS, rd);
        check(rd, 8'h0c, "periodic flag");
        u_host.write_reg(`CTRL2_OFS, 8'h08);
        check(irq_out_n_o, 1'b1, "periodic release");
        u_host.write_reg(`CTRL1_OFS, 8'h27);
        month_carry_i = 1'b1;
        wait_clk(1);
        month_carry_i = 1'b0;
        wait_clk(1);
        check(irq_out_n_o, 1'b0, "monthly irq");
        u_host.write_reg(`CTRL1_OFS, 8'h20);
    endtask : t_periodic

    task automatic t_day(input logic [7:0] mode, input logic [7:0] hr, input logic [7:0] wd, input time_t exp);
        u_host.write_reg(`CTRL1_OFS, mode);
        u_host.write_time('{sec: 8'h59, min: 8'h59, hour: hr, wday: wd});
        for (int k = 0; k < 1000 && day_carry_o !== 1'b1; k++) wait_clk(1);
        wait_clk(2);
        check(time_o, exp, "day rollover");
    endtask : t_day

    task automatic t_sec_restart();
        u_host.write_reg(`SECONDS_COUNT_OFS, 8'h10);
        wait_clk(480);
        check(time_o.sec, 8'h10, "second restarted");
        wait_clk(240);
        check(time_o.sec, 8'h11, "second tick");
    endtask : t_sec_restart

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        wait_clk(3);
        rst_n_i = 1'b1;
        t_power_on();
        t_flags();
        t_detect();
        t_alarm(0);
        t_alarm(1);
        t_periodic();
        t_day(8'h20, 8'h23, 8'h06, '{8'h00, 8'h00, 8'h00, 8'h00});
        t_day(8'h00, 8'h31, 8'h02, '{8'h00, 8'h00, 8'h12, 8'h03});
        t_sec_restart();
        u_host.write_reg(`CTRL1_OFS, 8'h21);
        wait_clk(5);
        check(irq_out_n_o, 1'b0, "fixed low irq");
        rst_n_i = 1'b0;
        wait_clk(3);
        rst_n_i = 1'b1;
        t_power_on();
        final_report();
    end

    initial begin
        #900000;
        n_fail++;
        final_report();
    end
endmodule : rtc_status_flags_time_counters_test
